/* src/ddrc_pkg.sv */
// package: command codes, bank count, timing constants and carriers for the command decoder
// How it works
// - chip select high or all strobes high: nothing registered, idle
// - row strobe alone low opens the row from the address lines in that bank
// - column strobe low with row strobe high starts a read burst or a write burst by write enable
// - column address is A0..Ai, organisation sets i, x4 adds line 11
// - line 10 sampled per access enables automatic precharge for that access only
// - automatic precharge closes the bank two cycles after the end of its burst
// - write enable alone low stops a read burst that has no automatic precharge
// - row strobe and write enable low close one bank, or all when line 10 high
// - row and column strobes low with write enable high refresh; clock enable low enters self refresh
// - refresh uses the internal counter and ignores address pins
// - in self refresh every input but clock enable is ignored
// - delay-locked loop off in self refresh; 200 cycles before a read
// - all strobes low load base or extended mode register by bank code
// - data mask high drops the write element, low writes it
// - closing a bank with no open row, or already closing, does nothing
package ddrc_pkg;
  localparam int BANKS      = 4;
  localparam int ROW_W      = 13;
  localparam int COL_W      = 12;
  localparam int APRE_BIT   = 10;
  localparam int X4_HI_BIT  = 11;
  localparam int COL_I_X16  = 8;
  localparam int COL_I_X8   = 9;
  localparam int CLK_NS     = 10;
  localparam int DLL_CYC    = 200;
  localparam int PRE_OFFSET = 2;
  localparam logic [1:0] MR_BASE = 2'h0;
  localparam logic [1:0] MR_EXT  = 2'h1;
  localparam logic [ROW_W-1:0] MR_RST = 13'h0000;

  typedef enum logic [1:0] {ORG_X4, ORG_X8, ORG_X16} ddrc_org_t;

  typedef enum logic [3:0] {
    CMD_IDLE, CMD_ROW_OPEN, CMD_READ, CMD_WRITE, CMD_BURST_STOP,
    CMD_ROW_CLOSE, CMD_REFRESH, CMD_SELF_ENTER, CMD_MODE_LOAD
  } ddrc_cmd_t;

  typedef struct packed {
    logic             csN;
    logic             rasN;
    logic             casN;
    logic             weN;
    logic             cke;
    logic [1:0]       bank;
    logic [ROW_W-1:0] addr;
  } ddrc_pins_t;

  typedef struct packed {
    ddrc_cmd_t        cmd;
    logic [1:0]       bank;
    logic [ROW_W-1:0] row;
    logic [COL_W-1:0] col;
    logic             autoPre;
    logic             allBanks;
  } ddrc_dec_t;
endpackage : ddrc_pkg

/* src/ddrc_bank_mem.sv */
// small memory holding the open row of each bank, registered read
module ddrc_bank_mem
  import ddrc_pkg::*;
#(
  parameter int DEPTH = BANKS,
  parameter int WIDTH = ROW_W
)(
  // clock
  input  wire logic                     clk_sys,
  // write port
  input  wire logic                     wrEn,
  input  wire logic [$clog2(DEPTH)-1:0] wrAddr,
  input  wire logic [WIDTH-1:0]         wrData,
  // read port
  input  wire logic [$clog2(DEPTH)-1:0] rdAddr,
  output logic      [WIDTH-1:0]         rdData
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk_sys)
  begin
    if (wrEn)
    begin
      mem[wrAddr] <= wrData;
    end
    rdData <= mem[rdAddr];
  end
endmodule : ddrc_bank_mem

/* src/ddrc_core.sv */
// command decoder, bank state, burst and refresh tracking of the memory device
module ddrc_core
  import ddrc_pkg::*;
#(
  parameter ddrc_org_t ORG   = ORG_X16,
  parameter int        BURST = 4,
  parameter int        CAS_L = 3
)(
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rstn,
  // command pins from the controller
  input  wire ddrc_pins_t       pins,
  // write data mask for the element in flight
  input  wire logic             wrMask,
  // decoded command, one cycle
  output ddrc_dec_t             dec,
  // per bank state
  output logic [BANKS-1:0]      bankOpen,
  output logic [ROW_W-1:0]      accessRow,
  // mode registers
  output logic [ROW_W-1:0]      modeBase,
  output logic [ROW_W-1:0]      modeExt,
  // refresh
  output logic [ROW_W+1:0]      refreshAddr,
  output logic                  refreshPulse,
  output logic                  selfRefresh,
  output logic                  dllOn,
  output logic                  dllLocked,
  // burst state
  output logic                  readActive,
  output logic                  writeActive,
  output logic                  arrayWrite
);
  localparam int BCYC = BURST / 2;
  localparam logic [7:0] DLL_CNT  = 8'(DLL_CYC);
  localparam logic [3:0] BURST_CNT = 4'(BCYC);
  localparam logic [3:0] PRE_CNT   = 4'(PRE_OFFSET);

  ddrc_dec_t decD;
  ddrc_dec_t decQ;
  logic [BANKS-1:0] openD, openQ, closingD, closingQ;
  logic [ROW_W-1:0] modeBaseD, modeBaseQ, modeExtD, modeExtQ;
  logic [ROW_W+1:0] refD, refQ;
  logic refPulseD, refPulseQ, selfD, selfQ;
  logic [7:0] dllCntD, dllCntQ;
  logic [3:0] burstCntD, burstCntQ, preCntD, preCntQ;
  logic rdD, rdQ, wrD, wrQ, apD, apQ;
  logic [1:0] burstBankD, burstBankQ, preBankD, preBankQ;
  logic arrayWrD, arrayWrQ;
  logic [COL_W-1:0] colSel;

  // column bits per organisation; line 10 is never part of it
  always_comb
  begin
    colSel = '0;
    case (ORG)
      ORG_X16: colSel[COL_I_X16:0] = pins.addr[COL_I_X16:0];
      ORG_X8:  colSel[COL_I_X8:0]  = pins.addr[COL_I_X8:0];
      default:
      begin
        colSel[COL_I_X8:0] = pins.addr[COL_I_X8:0];
        colSel[X4_HI_BIT]  = pins.addr[X4_HI_BIT];
      end
    endcase
  end

  // decode; self refresh masks all inputs but clock enable
  always_comb
  begin
    decD          = '0;
    decD.cmd      = CMD_IDLE;
    decD.bank     = pins.bank;
    decD.row      = pins.addr;
    decD.col      = colSel;
    decD.autoPre  = 1'b0;
    decD.allBanks = 1'b0;
    if (selfQ || pins.csN)
    begin
      decD.cmd = CMD_IDLE;
    end
    else if (!pins.rasN && pins.casN && pins.weN)
    begin
      decD.cmd = CMD_ROW_OPEN;
    end
    else if (pins.rasN && !pins.casN)
    begin
      decD.cmd     = pins.weN ? CMD_READ : CMD_WRITE;
      decD.autoPre = pins.addr[APRE_BIT];
    end
    else if (pins.rasN && pins.casN && !pins.weN)
    begin
      decD.cmd = CMD_BURST_STOP;
    end
    else if (!pins.rasN && pins.casN && !pins.weN)
    begin
      decD.cmd      = CMD_ROW_CLOSE;
      decD.allBanks = pins.addr[APRE_BIT];
    end
    else if (!pins.rasN && !pins.casN && pins.weN)
    begin
      decD.cmd = pins.cke ? CMD_REFRESH : CMD_SELF_ENTER;
    end
    else if (!pins.rasN && !pins.casN && !pins.weN)
    begin
      decD.cmd = CMD_MODE_LOAD;
    end
  end

  // bursts, auto precharge, bank and mode state
  always_comb
  begin
    openD      = openQ;
    closingD   = '0;
    modeBaseD  = modeBaseQ;
    modeExtD   = modeExtQ;
    burstCntD  = burstCntQ;
    rdD        = rdQ;
    wrD        = wrQ;
    apD        = apQ;
    burstBankD = burstBankQ;
    preCntD    = preCntQ;
    preBankD   = preBankQ;
    if (burstCntQ != 4'h0)
    begin
      burstCntD = burstCntQ - 4'h1;
      if (burstCntQ == 4'h1)
      begin
        rdD = 1'b0;
        wrD = 1'b0;
        if (apQ)
        begin
          preCntD  = PRE_CNT;
          preBankD = burstBankQ;
          apD      = 1'b0;
        end
      end
    end
    if (preCntQ != 4'h0)
    begin
      preCntD            = preCntQ - 4'h1;
      closingD[preBankQ] = 1'b1;
      if (preCntQ == 4'h1)
      begin
        openD[preBankQ] = 1'b0;
      end
    end
    case (decD.cmd)
      CMD_ROW_OPEN: openD[decD.bank] = 1'b1;
      CMD_READ, CMD_WRITE:
      begin
        burstCntD  = BURST_CNT;
        rdD        = (decD.cmd == CMD_READ);
        wrD        = (decD.cmd == CMD_WRITE);
        apD        = decD.autoPre;
        burstBankD = decD.bank;
      end
      CMD_BURST_STOP:
      begin
        if (rdQ && !apQ)
        begin
          burstCntD = 4'h0;
          rdD       = 1'b0;
        end
      end
      CMD_ROW_CLOSE:
      begin
        for (int b = 0; b < BANKS; b++)
        begin
          if ((decD.allBanks || decD.bank == 2'(b)) && !closingQ[b])
          begin
            openD[b] = 1'b0;
          end
        end
      end
      CMD_MODE_LOAD:
      begin
        if (decD.bank == MR_BASE)
        begin
          modeBaseD = decD.row;
        end
        else if (decD.bank == MR_EXT)
        begin
          modeExtD = decD.row;
        end
      end
      default: ;
    endcase
  end

  // refresh counter, self refresh and delay-locked loop
  always_comb
  begin
    refD      = refQ;
    refPulseD = 1'b0;
    selfD     = selfQ;
    dllCntD   = dllCntQ;
    if (decD.cmd == CMD_REFRESH || decD.cmd == CMD_SELF_ENTER)
    begin
      refD      = refQ + 15'h1;
      refPulseD = 1'b1;
    end
    if (decD.cmd == CMD_SELF_ENTER)
    begin
      selfD   = 1'b1;
      dllCntD = 8'h0;
    end
    else if (selfQ && pins.cke)
    begin
      selfD = 1'b0;
    end
    else if (!selfQ && dllCntQ != DLL_CNT)
    begin
      dllCntD = dllCntQ + 8'h1;
    end
  end

  assign arrayWrD = wrQ && !wrMask;

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      decQ       <= '0;
      openQ      <= '0;
      closingQ   <= '0;
      modeBaseQ  <= MR_RST;
      modeExtQ   <= MR_RST;
      refQ       <= '0;
      refPulseQ  <= 1'b0;
      selfQ      <= 1'b0;
      dllCntQ    <= 8'h0;
      burstCntQ  <= 4'h0;
      rdQ        <= 1'b0;
      wrQ        <= 1'b0;
      apQ        <= 1'b0;
      burstBankQ <= 2'h0;
      preCntQ    <= 4'h0;
      preBankQ   <= 2'h0;
      arrayWrQ   <= 1'b0;
    end
    else
    begin
      decQ       <= decD;
      openQ      <= openD;
      closingQ   <= closingD;
      modeBaseQ  <= modeBaseD;
      modeExtQ   <= modeExtD;
      refQ       <= refD;
      refPulseQ  <= refPulseD;
      selfQ      <= selfD;
      dllCntQ    <= dllCntD;
      burstCntQ  <= burstCntD;
      rdQ        <= rdD;
      wrQ        <= wrD;
      apQ        <= apD;
      burstBankQ <= burstBankD;
      preCntQ    <= preCntD;
      preBankQ   <= preBankD;
      arrayWrQ   <= arrayWrD;
    end
  end

  // open row per bank, written on row open, read at access
  ddrc_bank_mem #(.DEPTH(BANKS), .WIDTH(ROW_W)) uRows (
    .clk_sys (clk_sys),
    .wrEn    (decD.cmd == CMD_ROW_OPEN),
    .wrAddr  (decD.bank),
    .wrData  (decD.row),
    .rdAddr  (decD.bank),
    .rdData  (accessRow)
  );

  assign dec          = decQ;
  assign bankOpen     = openQ;
  assign modeBase     = modeBaseQ;
  assign modeExt      = modeExtQ;
  assign refreshAddr  = refQ;
  assign refreshPulse = refPulseQ;
  assign selfRefresh  = selfQ;
  assign dllOn        = !selfQ;
  assign dllLocked    = !selfQ && (dllCntQ == DLL_CNT);
  assign readActive   = rdQ;
  assign writeActive  = wrQ;
  assign arrayWrite   = arrayWrQ;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  a_deselect_idle: assert property (pins.csN && !selfQ |=> decQ.cmd == CMD_IDLE)
    else $error("deselect registered a command");
  a_row_open_sets: assert property (decD.cmd == CMD_ROW_OPEN |=> openQ[$past(pins.bank)])
    else $error("row open did not mark bank");
  a_read_decode: assert property (!selfQ && !pins.csN && pins.rasN && !pins.casN && pins.weN
    |=> decQ.cmd == CMD_READ && rdQ)
    else $error("read not decoded");
  a_autopre_sample: assert property (decD.cmd inside {CMD_READ, CMD_WRITE}
    |=> apQ == $past(pins.addr[APRE_BIT]))
    else $error("auto precharge not sampled");
  a_autopre_close: assert property (burstCntQ == 4'h1 && apQ && decD.cmd == CMD_IDLE
    ##1 decD.cmd == CMD_IDLE [*2] |=> !openQ[$past(burstBankQ, 3)])
    else $error("auto precharge did not close bank");
  a_stop_read: assert property (decD.cmd == CMD_BURST_STOP && rdQ && !apQ |=> !rdQ)
    else $error("burst stop ignored");
  a_close_all: assert property (decD.cmd == CMD_ROW_CLOSE && decD.allBanks && closingQ == '0
    && preCntQ == 4'h0 |=> openQ == '0)
    else $error("close all left a bank open");
  a_self_enter: assert property (decD.cmd == CMD_SELF_ENTER |=> selfQ && !dllOn)
    else $error("self refresh not entered");
  a_refresh_count: assert property (decD.cmd == CMD_REFRESH |=> refQ == $past(refQ) + 15'h1)
    else $error("refresh counter did not advance");
  a_self_ignore: assert property (selfQ && !pins.cke |=> decQ.cmd == CMD_IDLE)
    else $error("input honoured in self refresh");
  a_dll_relock: assert property ($fell(selfQ) |-> !dllLocked [*8])
    else $error("delay-locked loop locked too early");
  a_mode_ext: assert property (decD.cmd == CMD_MODE_LOAD && decD.bank == MR_EXT
    |=> modeExtQ == $past(pins.addr))
    else $error("extended mode not loaded");
  a_mask_write: assert property (wrQ && wrMask |=> !arrayWrQ)
    else $error("masked element written");

  c_read_ap: cover property (decD.cmd == CMD_READ && decD.autoPre);
  c_stop: cover property (decD.cmd == CMD_BURST_STOP && rdQ);
  c_self: cover property (selfQ ##1 !selfQ);
  c_mode: cover property (decD.cmd == CMD_MODE_LOAD);
endmodule : ddrc_core

/* verification/ddrc_ctrl_model.sv */
// controller model driving the command pins and write mask of the memory device
module ddrc_ctrl_model
  import ddrc_pkg::*;
(
  // clock
  input  wire logic  clk_sys,
  // command side
  output ddrc_pins_t pins,
  output logic       wrMask
);
  timeunit 1ns;
  timeprecision 100ps;

  logic ckeLvl;

  initial
  begin
    ckeLvl = 1'b1;
    wrMask = 1'b1;
    pins   = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 2'h0, 13'h0000};
  end

  // one command for one cycle, entered 1 ns after a rising edge
  task automatic issue(input logic [3:0] stb, input logic [1:0] bnk,
                       input logic [ROW_W-1:0] adr, input logic ck = 1'b1);
    ckeLvl = ck;
    pins   = '{stb[3], stb[2], stb[1], stb[0], ck, bnk, adr};
    @(posedge clk_sys);
    #1;
  endtask : issue

  // released address lines do not keep their last value
  task automatic nop(input int n);
    repeat (n)
      issue(4'hf, ~pins.bank, ~pins.addr, ckeLvl);
  endtask : nop

  // clock already stable, so cke may rise under deselect
  task automatic wake();
    issue(4'hf, ~pins.bank, ~pins.addr, 1'b1);
  endtask : wake

  task automatic mask(input logic v);
    wrMask = v;
  endtask : mask
endmodule : ddrc_ctrl_model

/* verification/ddrc_core_tb.sv */
// self-checking testbench of the command decoder and refresh logic
module ddrc_core_tb
  import ddrc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  localparam logic [3:0] OPN = 4'h3;
  localparam logic [3:0] RD  = 4'h5;
  localparam logic [3:0] WR  = 4'h4;
  localparam logic [3:0] STP = 4'h6;
  localparam logic [3:0] CLS = 4'h2;
  localparam logic [3:0] REF = 4'h1;
  localparam logic [3:0] MLD = 4'h0;

  logic             clk_sys = 1'b0;
  logic             rstn    = 1'b0;
  ddrc_pins_t       pins;
  logic             wrMask;
  ddrc_dec_t        dec;
  logic [BANKS-1:0] bankOpen;
  logic [ROW_W-1:0] accessRow;
  logic [ROW_W-1:0] modeBase;
  logic [ROW_W-1:0] modeExt;
  logic [ROW_W+1:0] refreshAddr;
  logic             refreshPulse;
  logic             selfRefresh;
  logic             dllOn;
  logic             dllLocked;
  logic             readActive;
  logic             writeActive;
  logic             arrayWrite;
  int               n_fail = 0;
  int               samples_checked = 0;

  always #5 clk_sys = ~clk_sys;

  ddrc_ctrl_model i_m (.clk_sys(clk_sys), .pins(pins), .wrMask(wrMask));

  ddrc_core i_ddrc_core (
    .clk_sys(clk_sys), .rstn(rstn), .pins(pins), .wrMask(wrMask), .dec(dec),
    .bankOpen(bankOpen), .accessRow(accessRow), .modeBase(modeBase),
    .modeExt(modeExt), .refreshAddr(refreshAddr), .refreshPulse(refreshPulse),
    .selfRefresh(selfRefresh), .dllOn(dllOn), .dllLocked(dllLocked),
    .readActive(readActive), .writeActive(writeActive), .arrayWrite(arrayWrite)
  );

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic results();
    if (n_fail == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : results

  // mode loads issued while every bank is idle; bank code 2 loads neither register
  task automatic t_mode();
    chk({modeBase, modeExt, bankOpen, dllOn}, 32'h1);
    i_m.issue(MLD, 2'h0, 13'h0123);
    chk(dec.cmd, CMD_MODE_LOAD);
    chk(modeBase, 13'h0123);
    i_m.issue(MLD, 2'h1, 13'h0a5a);
    chk(modeExt, 13'h0a5a);
    i_m.issue(MLD, 2'h2, 13'h1fff);
    chk({modeBase, modeExt}, {13'h0123, 13'h0a5a});
  endtask : t_mode

  task automatic t_rd();
    i_m.issue(OPN, 2'h2, 13'h1abc);
    chk({dec.cmd, dec.bank, dec.row}, {CMD_ROW_OPEN, 2'h2, 13'h1abc});
    chk(bankOpen, 4'h4);
    i_m.issue(RD, 2'h2, 13'h1bff);
    chk({dec.cmd, dec.col, dec.autoPre}, {CMD_READ, 12'h1ff, 1'b0});
    chk(readActive, 1'b1);
    chk(accessRow, 13'h1abc);
    i_m.issue(STP, 2'h0, 13'h0000);
    chk(dec.cmd, CMD_BURST_STOP);
    chk(readActive, 1'b0);
  endtask : t_rd

  // first write fully masked, second with auto precharge unmasked
  task automatic t_wr(input logic [12:0] adr, input logic m);
    logic aw;
    i_m.mask(m);
    i_m.issue(WR, 2'h2, adr);
    chk({dec.cmd, dec.col, dec.autoPre}, {CMD_WRITE, 3'h0, adr[8:0], adr[10]});
    chk({writeActive, bankOpen}, 5'h14);
    aw = arrayWrite;
    repeat (4)
    begin
      i_m.nop(1);
      aw = aw | arrayWrite;
    end
    i_m.nop(1);
    chk(aw, !m);
    chk(bankOpen, adr[10] ? 4'h0 : 4'h4);
    i_m.mask(1'b1);
  endtask : t_wr

  task automatic t_close();
    i_m.issue(OPN, 2'h0, 13'h0011);
    i_m.issue(OPN, 2'h1, 13'h0022);
    chk(bankOpen, 4'h3);
    i_m.issue(CLS, 2'h0, 13'h1bff);
    chk(bankOpen, 4'h2);
    i_m.issue(CLS, 2'h0, 13'h0000);
    chk(bankOpen, 4'h2);
    i_m.issue(CLS, 2'h3, 13'h0400);
    chk(bankOpen, 4'h0);
    chk({dec.cmd, dec.allBanks}, {CMD_ROW_CLOSE, 1'b1});
  endtask : t_close

  task automatic t_ref();
    logic [ROW_W+1:0] ra;
    ra = refreshAddr;
    i_m.issue(REF, 2'h3, 13'h1fff);
    chk({dec.cmd, refreshPulse, selfRefresh}, {CMD_REFRESH, 2'h2});
    chk(refreshAddr, ra + 15'h1);
    i_m.issue(4'h8, 2'h1, 13'h0003);
    chk({dec.cmd, refreshPulse}, {CMD_IDLE, 1'b0});
    i_m.issue(4'h7, 2'h1, 13'h0003);
    chk({dec.cmd, bankOpen}, {CMD_IDLE, 4'h0});
  endtask : t_ref

  task automatic t_self();
    i_m.issue(REF, 2'h0, 13'h0000, 1'b0);
    chk({dec.cmd, refreshPulse}, {CMD_SELF_ENTER, 1'b1});
    chk({selfRefresh, dllOn}, 2'h2);
    i_m.issue(OPN, 2'h1, 13'h0055, 1'b0);
    chk({dec.cmd, bankOpen}, {CMD_IDLE, 4'h0});
    i_m.wake();
    i_m.nop(2);
    chk({selfRefresh, dllOn, dllLocked}, 3'h2);
    i_m.nop(205);
    chk(dllLocked, 1'b1);
  endtask : t_self

  // reset in mid-run drops bank and mode state, first command right after
  task automatic t_reset();
    i_m.issue(OPN, 2'h3, 13'h0123);
    chk(bankOpen, 4'h8);
    rstn = 1'b0;
    i_m.nop(1);
    rstn = 1'b1;
    chk({bankOpen, modeBase, selfRefresh, dllOn, dllLocked}, 20'h2);
    i_m.issue(OPN, 2'h1, 13'h0077);
    chk({dec.cmd, bankOpen}, {CMD_ROW_OPEN, 4'h2});
  endtask : t_reset

  // whole run is a few microseconds; well short of this limit
  initial
  begin
    #20000;
    n_fail++;
    results();
  end

  initial
  begin
    repeat (2) @(posedge clk_sys);
    #1;
    rstn = 1'b1;
    t_mode();
    t_rd();
    t_wr(13'h0008, 1'b1);
    t_wr(13'h0404, 1'b0);
    t_close();
    t_ref();
    t_self();
    t_reset();
    results();
  end
endmodule : ddrc_core_tb
